// file: aolu_top.sv
/*
 * Accumulator datapath executing the word, double and bit-field OR forms.
 * Assumes the sequencer holds operands valid while i_op_valid is high and
 * the discrete memory answers o_bit_addr combinationally.
 */
`timescale 1ns/1ns
// Overview of operation
// - Word OR: low half with memory word.
// - Word OR updates only the zero flag.
// - Double OR: full accumulator with 32-bit operand.
// - Double OR sets zero and negative flags.
// - Bit-field OR gathers 1 to 32 bits.
// - Bit-field OR sets zero and negative flags.
module aolu_top (
  // Clock and reset
  input  wire logic                         i_clk_sys,
  input  wire logic                         i_resetn,
  // Operation request
  input  wire logic                         i_op_valid,
  input  wire logic [1:0]                   i_op_kind,
  input  wire logic                         i_rung,
  output logic                              o_op_ready,
  output logic                              o_op_done,
  // Operands
  input  wire logic [15:0]                  i_mem_word,
  input  wire logic [31:0]                  i_dbl_operand,
  input  wire logic [aolu_pkg::BADDR_W-1:0] i_bit_start,
  input  wire logic [aolu_pkg::CNT_W-1:0]   i_bit_count,
  // Accumulator load
  input  wire logic                         i_acc_load,
  input  wire logic [31:0]                  i_acc_value,
  // Discrete memory read port
  output logic [aolu_pkg::BADDR_W-1:0]      o_bit_addr,
  input  wire logic                         i_bit_data,
  // Results
  output logic [31:0]                       o_acc,
  output logic                              o_zero_result_flag,
  output logic                              o_negative_result_flag
);

  aolu_pkg::aolu_main_s r;
  aolu_pkg::aolu_main_s next_r;
  aolu_gather_if        gif ();
  logic                 accept;
  logic                 cnt_ok;
  logic                 do_gather;
  logic [31:0]          res;

  // ----------------------------------------------------------------
  // Bit gatherer
  // ----------------------------------------------------------------
  aolu_bit_gather u_gather (
    .i_clk_sys  (i_clk_sys),
    .i_resetn   (i_resetn),
    .gif        (gif),
    .o_bit_addr (o_bit_addr),
    .i_bit_data (i_bit_data)
  );

  assign o_op_ready = (r.state == aolu_pkg::AOLU_ST_IDLE);
  assign accept     = i_op_valid && o_op_ready;
  assign cnt_ok     = (i_bit_count >= aolu_pkg::CNT_MIN) && (i_bit_count <= aolu_pkg::CNT_MAX);
  assign do_gather  = i_rung && cnt_ok && (i_op_kind == aolu_pkg::AOLU_OP_BITFIELD);
  assign gif.start      = accept && do_gather;
  assign gif.start_addr = i_bit_start;
  assign gif.count      = i_bit_count;

  // ----------------------------------------------------------------
  // Operation control
  // ----------------------------------------------------------------
  always_comb begin
    next_r      = r;
    next_r.done = 1'b0;
    res         = '0;
    unique case (r.state)
      aolu_pkg::AOLU_ST_IDLE: begin
        if (accept) begin
          next_r.done = !do_gather;
          if (do_gather) begin
            next_r.state = aolu_pkg::AOLU_ST_GATHER;
          end else if (i_rung && (i_op_kind == aolu_pkg::AOLU_OP_WORD)) begin
            res         = {aolu_pkg::UPPER_CLR, r.acc[15:0] | i_mem_word};
            next_r.acc  = res;
            next_r.zero = (res == '0);
          end else if (i_rung && (i_op_kind == aolu_pkg::AOLU_OP_DOUBLE)) begin
            res         = r.acc | i_dbl_operand;
            next_r.acc  = res;
            next_r.zero = (res == '0);
            next_r.neg  = res[31];
          end
        end else if (i_acc_load) begin
          next_r.acc = i_acc_value;
        end
      end
      aolu_pkg::AOLU_ST_GATHER: begin
        if (gif.done) begin
          res          = r.acc | gif.pattern;
          next_r.acc   = res;
          next_r.zero  = (res == '0);
          next_r.neg   = res[31];
          next_r.done  = 1'b1;
          next_r.state = aolu_pkg::AOLU_ST_IDLE;
        end
      end
      default: begin
        next_r.state = aolu_pkg::AOLU_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      r <= '{state: aolu_pkg::AOLU_ST_IDLE, acc: aolu_pkg::ACC_RST, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign o_acc                  = r.acc;
  assign o_zero_result_flag     = r.zero;
  assign o_negative_result_flag = r.neg;
  assign o_op_done              = r.done;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic take_word;
  logic take_dbl;
  logic take_bf;
  assign take_word = accept && i_rung && (i_op_kind == aolu_pkg::AOLU_OP_WORD);
  assign take_dbl  = accept && i_rung && (i_op_kind == aolu_pkg::AOLU_OP_DOUBLE);
  assign take_bf   = accept && do_gather;

  property p_word_result;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      take_word |=> (o_acc == {16'h0000, $past(r.acc[15:0]) | $past(i_mem_word)});
  endproperty
  a_word_result: assert property (p_word_result) else $error("word OR result wrong");

  property p_word_flags;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      take_word |=> (o_zero_result_flag == (o_acc == 32'h00000000))
                    && $stable(o_negative_result_flag) && o_op_done;
  endproperty
  a_word_flags: assert property (p_word_flags) else $error("word OR flags wrong");

  property p_dbl_result;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      take_dbl |=> (o_acc == ($past(r.acc) | $past(i_dbl_operand)));
  endproperty
  a_dbl_result: assert property (p_dbl_result) else $error("double OR result wrong");

  property p_dbl_flags;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      take_dbl |=> (o_zero_result_flag == (o_acc == 32'h00000000))
                   && (o_negative_result_flag == o_acc[31]);
  endproperty
  a_dbl_flags: assert property (p_dbl_flags) else $error("double OR flags wrong");

  property p_bf_result;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (r.state == aolu_pkg::AOLU_ST_GATHER) && gif.done
        |=> (o_acc == ($past(r.acc) | $past(gif.pattern))) && o_op_done;
  endproperty
  a_bf_result: assert property (p_bf_result) else $error("bit-field OR result wrong");

  property p_bf_flags;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      take_bf |-> ##[2:34] (o_op_done && (o_zero_result_flag == (o_acc == 32'h00000000))
                            && (o_negative_result_flag == o_acc[31]));
  endproperty
  a_bf_flags: assert property (p_bf_flags) else $error("bit-field OR flags late or wrong");

  property p_rung_off;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      accept && !i_rung |=> $stable(o_acc) && $stable(o_zero_result_flag)
                            && $stable(o_negative_result_flag) && o_op_done;
  endproperty
  a_rung_off: assert property (p_rung_off) else $error("false rung changed state");

  property p_busy_refuse;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      take_bf |=> !o_op_ready [*2];
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("ready during gather");

  property p_gather_start;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      take_bf |=> gif.busy && (o_bit_addr == $past(i_bit_start));
  endproperty
  a_gather_start: assert property (p_gather_start) else $error("gather start wrong");

  property p_bad_count;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      accept && i_rung && (i_op_kind == aolu_pkg::AOLU_OP_BITFIELD) && !cnt_ok
        |=> $stable(o_acc) && $stable(o_zero_result_flag) && o_op_done;
  endproperty
  a_bad_count: assert property (p_bad_count) else $error("bad bit count changed state");

  property p_bf_back_ready;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (r.state == aolu_pkg::AOLU_ST_GATHER) && gif.done |=> o_op_ready;
  endproperty
  a_bf_back_ready: assert property (p_bf_back_ready) else $error("not ready after gather");

  c_word:  cover property (@(posedge i_clk_sys) disable iff (!i_resetn) take_word);
  c_dbl:   cover property (@(posedge i_clk_sys) disable iff (!i_resetn) take_dbl ##1 o_negative_result_flag);
  c_bf32:  cover property (@(posedge i_clk_sys) disable iff (!i_resetn)
                           take_bf && (i_bit_count == 6'h20));
  c_badcnt: cover property (@(posedge i_clk_sys) disable iff (!i_resetn)
                            accept && i_rung && (i_op_kind == 2'h2) && !cnt_ok);

endmodule : aolu_top

// file: aolu_pkg.sv
/*
 * Shared constants and types for the accumulator logical-OR unit.
 * Assumes one CPU clock and a sequencer that issues one operation at a time.
 */
package aolu_pkg;

  // ----------------------------------------------------------------
  // Widths and ranges
  // ----------------------------------------------------------------
  localparam int          ACC_W     = 32;
  localparam int          WORD_W    = 16;
  localparam int          BADDR_W   = 12;
  localparam int          CNT_W     = 6;
  localparam int          IDX_W     = 5;
  localparam logic [5:0]  CNT_MIN   = 6'h01;
  localparam logic [5:0]  CNT_MAX   = 6'h20;
  localparam logic [31:0] ACC_RST   = 32'h00000000;
  localparam logic [15:0] UPPER_CLR = 16'h0000;

  // ----------------------------------------------------------------
  // Operation kinds and controller states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    AOLU_OP_WORD     = 2'h0,
    AOLU_OP_DOUBLE   = 2'h1,
    AOLU_OP_BITFIELD = 2'h2
  } aolu_op_e;

  typedef enum logic [1:0] {
    AOLU_ST_IDLE   = 2'b01,
    AOLU_ST_GATHER = 2'b10
  } aolu_state_e;

  // ----------------------------------------------------------------
  // State records
  // ----------------------------------------------------------------
  typedef struct packed {
    aolu_state_e  state;
    logic [31:0]  acc;
    logic         zero;
    logic         neg;
    logic         done;
  } aolu_main_s;

  typedef struct packed {
    logic               busy;
    logic               done;
    logic [BADDR_W-1:0] addr;
    logic [CNT_W-1:0]   cnt;
    logic [IDX_W-1:0]   idx;
    logic [ACC_W-1:0]   pattern;
  } aolu_gather_s;

endpackage : aolu_pkg

// file: aolu_gather_if.sv
/*
 * Carrier between the unit's controller and its discrete-bit gatherer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
interface aolu_gather_if;
  logic                        start;
  logic [aolu_pkg::BADDR_W-1:0] start_addr;
  logic [aolu_pkg::CNT_W-1:0]   count;
  logic                        busy;
  logic                        done;
  logic [aolu_pkg::ACC_W-1:0]   pattern;

  modport ctrl     (output start, start_addr, count, input busy, done, pattern);
  modport gatherer (input start, start_addr, count, output busy, done, pattern);
endinterface : aolu_gather_if

// file: aolu_bit_gather.sv
/*
 * Reads a run of consecutive discrete bits, one per clock, into a pattern.
 * Assumes the discrete memory answers a read address in the same cycle.
 */
`timescale 1ns/1ns
module aolu_bit_gather (
  // Clock and reset
  input  wire logic                         i_clk_sys,
  input  wire logic                         i_resetn,
  // Controller side
  aolu_gather_if.gatherer                   gif,
  // Discrete memory read port
  output logic [aolu_pkg::BADDR_W-1:0]      o_bit_addr,
  input  wire logic                         i_bit_data
);

  aolu_pkg::aolu_gather_s r;
  aolu_pkg::aolu_gather_s next_r;

  // ----------------------------------------------------------------
  // Gather sequence
  // ----------------------------------------------------------------
  always_comb begin
    next_r      = r;
    next_r.done = 1'b0;
    if (!r.busy) begin
      if (gif.start) begin
        next_r.busy    = 1'b1;
        next_r.addr    = gif.start_addr;
        next_r.cnt     = gif.count;
        next_r.idx     = '0;
        next_r.pattern = '0;
      end
    end else begin
      next_r.pattern[r.idx] = i_bit_data;
      next_r.addr           = r.addr + 12'h001;
      next_r.idx            = r.idx + 5'h01;
      if ({1'b0, r.idx} == (r.cnt - aolu_pkg::CNT_MIN)) begin
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign o_bit_addr  = r.addr;
  assign gif.busy    = r.busy;
  assign gif.done    = r.done;
  assign gif.pattern = r.pattern;

endmodule : aolu_bit_gather

// file: aolu_disc_mem.sv
/*
 * Model of the discrete bit memory behind the unit's gatherer.
 * Assumes the bench fills every bit through the write port before use.
 */
`timescale 1ns/1ns
module aolu_disc_mem (
  // Clock and write port
  input  wire logic                         i_clk_sys,
  input  wire logic                         i_wr,
  input  wire logic [aolu_pkg::BADDR_W-1:0] i_wr_addr,
  input  wire logic                         i_wr_bit,
  // Read port
  input  wire logic [aolu_pkg::BADDR_W-1:0] i_addr,
  output logic                              o_data
);
  logic mem [0:4095];
  always_ff @(posedge i_clk_sys) begin
    if (i_wr) begin
      mem[i_wr_addr] <= i_wr_bit;
    end
  end
  assign o_data = mem[i_addr];
endmodule : aolu_disc_mem

// file: testbench.sv
/*
 * Self-checking bench for the accumulator OR unit against a queue-free model.
 * Assumes the partner memory answers a bit address in the same cycle.
 */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %s exp=%h got=%h", nm, e, g); end end
module testbench;
  logic        i_clk_sys = 1'h0, i_resetn = 1'h0, i_op_valid = 1'h0, i_rung = 1'h0;
  logic        i_acc_load = 1'h0, wr = 1'h0, wbit = 1'h0, i_bit_data, o_op_ready, o_op_done;
  logic        o_zero_result_flag, o_negative_result_flag, m_z = 1'h0, m_n = 1'h0;
  logic [1:0]  i_op_kind = 2'h0;
  logic [15:0] i_mem_word = 16'h0;
  logic [31:0] i_dbl_operand = 32'h0, i_acc_value = 32'h0, o_acc, m_acc = 32'h0;
  logic [11:0] i_bit_start = 12'h0, o_bit_addr, waddr = 12'h0;
  logic [5:0]  i_bit_count = 6'h0;
  bit          img [0:4095];
  int          n_fail = 0, n_checks = 0, cyc = 0;

  aolu_top dut_u (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_op_valid(i_op_valid),
    .i_op_kind(i_op_kind), .i_rung(i_rung), .o_op_ready(o_op_ready), .o_op_done(o_op_done),
    .i_mem_word(i_mem_word), .i_dbl_operand(i_dbl_operand), .i_bit_start(i_bit_start),
    .i_bit_count(i_bit_count), .i_acc_load(i_acc_load), .i_acc_value(i_acc_value),
    .o_bit_addr(o_bit_addr), .i_bit_data(i_bit_data), .o_acc(o_acc),
    .o_zero_result_flag(o_zero_result_flag), .o_negative_result_flag(o_negative_result_flag));
  aolu_disc_mem mem_u (.i_clk_sys(i_clk_sys), .i_wr(wr), .i_wr_addr(waddr), .i_wr_bit(wbit),
    .i_addr(o_bit_addr), .o_data(i_bit_data));

  initial begin
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  task automatic results();
    $display("checks=%0d failures=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  // Drives one request at a falling edge and checks the model at its result.
  task automatic op(input logic [1:0] k, input logic r, input logic [15:0] w,
                    input logic [31:0] d, input logic [11:0] s, input logic [5:0] c);
    int          lat;
    int          n;
    logic [31:0] pat;
    lat = 1;
    pat = 32'h0;
    i_op_valid = 1'h1;
    i_op_kind = k;
    i_rung = r;
    i_mem_word = w;
    i_dbl_operand = d;
    i_bit_start = s;
    i_bit_count = c;
    if (r) begin
      case (k)
        2'h0: m_acc = {16'h0, m_acc[15:0] | w};
        2'h1: m_acc = m_acc | d;
        2'h2: if (c >= 6'h01 && c <= 6'h20) begin
          for (int i = 0; i < int'(c); i++) pat[i] = img[int'(s) + i];
          m_acc = m_acc | pat;
          // One cycle to start the gatherer, one per bit (done comes with the last), then the result register.
          lat = int'(c) + 2;
        end
        default: ;
      endcase
      if (k != 2'h3 && (k != 2'h2 || lat > 1)) begin
        m_z = (m_acc == 32'h0);
        if (k != 2'h0) m_n = m_acc[31];
      end
    end
    @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    n = 1;
    if (lat > 1) `CHK("ready", 1'h0, o_op_ready)
    while (o_op_done !== 1'h1 && n < 40) begin
      @(negedge i_clk_sys);
      n++;
    end
    `CHK("latency", lat, n)
    `CHK("acc", m_acc, o_acc)
    `CHK("zero", m_z, o_zero_result_flag)
    `CHK("neg", m_n, o_negative_result_flag)
  endtask : op

  task automatic idle();
    i_op_valid = 1'h0;
    @(negedge i_clk_sys);
    `CHK("done_pulse", 1'h0, o_op_done)
    `CHK("zero_hold", m_z, o_zero_result_flag)
    `CHK("neg_hold", m_n, o_negative_result_flag)
  endtask : idle

  task automatic load(input logic [31:0] v);
    i_acc_load = 1'h1;
    i_acc_value = v;
    @(negedge i_clk_sys);
    i_acc_load = 1'h0;
    m_acc = v;
    `CHK("load", m_acc, o_acc)
  endtask : load

  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      results();
    end
  end

  initial begin
    void'($urandom(54549));
    repeat (20) @(negedge i_clk_sys);
    i_resetn = 1'h1;
    `CHK("rst_acc", 32'h0, o_acc)
    for (int a = 0; a < 4096; a++) begin
      wr = 1'h1;
      waddr = a[11:0];
      wbit = 1'($urandom);
      img[a] = wbit;
      @(negedge i_clk_sys);
    end
    wr = 1'h0;
    load(32'hFFFF0000);
    op(2'h0, 1'h1, 16'h0, 32'h0, 12'h0, 6'h0);
    op(2'h0, 1'h1, 16'h8001, 32'h0, 12'h0, 6'h0);
    op(2'h1, 1'h0, 16'h0, 32'hFFFFFFFF, 12'h0, 6'h0);
    op(2'h1, 1'h1, 16'h0, 32'h80000000, 12'h0, 6'h0);
    op(2'h1, 1'h1, 16'h0, 32'hFFFFFFFF, 12'h0, 6'h0);
    idle();
    load(32'h0);
    op(2'h2, 1'h1, 16'h0, 32'h0, 12'h064, 6'h20);
    op(2'h2, 1'h1, 16'h0, 32'h0, 12'hFDF, 6'h01);
    op(2'h2, 1'h1, 16'h0, 32'h0, 12'h010, 6'h00);
    op(2'h2, 1'h1, 16'h0, 32'h0, 12'h010, 6'h21);
    op(2'h2, 1'h0, 16'h0, 32'h0, 12'h010, 6'h08);
    op(2'h3, 1'h1, 16'hFFFF, 32'h0, 12'h0, 6'h0);
    for (int j = 0; j < 200; j++) begin
      if (j % 16 == 0) begin
        idle();
        load($urandom);
      end
      // counts mostly within 1 to 32
      op(2'($urandom_range(0, 3)), 1'($urandom_range(0, 7) != 0), 16'($urandom), $urandom,
         12'($urandom_range(0, 4032)), 6'($urandom_range(0, 36)));
    end
    idle();
    results();
  end
endmodule : testbench
